// *** include/tna_pkg.sv ***
/*
  tna_pkg: operation codes, field positions, widths and reset values
  for the timer nibble access unit.
  assumes: the cpu core and the timers share sys_clk with this unit.
*/
package tna_pkg;

  localparam int TNA_NIB_W = 4;
  localparam int TNA_CNT_W = 8;
  localparam int TNA_OP_W = 4;

  // interrupt enable bit positions in the two control nibbles
  localparam int TNA_FIRST_TIMER_IRQ_ENABLE_BIT = 2;
  localparam int TNA_SECOND_TIMER_IRQ_ENABLE_BIT = 3;
  localparam int TNA_THIRD_TIMER_IRQ_ENABLE_BIT = 0;

  // reset values
  localparam logic [7:0] TNA_RELOAD_RESET = 8'h00;
  localparam logic [3:0] TNA_NIB_RESET = 4'h0;

  typedef enum logic [3:0] {
    TNA_OP_READ_PRESCALE = 4'h0,
    TNA_OP_WRITE_PRESCALE = 4'h1,
    TNA_OP_READ_T1 = 4'h2,
    TNA_OP_WRITE_T1 = 4'h3,
    TNA_OP_WRITE_T1_RELOAD_ONLY = 4'h4,
    TNA_OP_READ_T2 = 4'h5,
    TNA_OP_WRITE_T2 = 4'h6,
    TNA_OP_READ_T3 = 4'h7,
    TNA_OP_WRITE_T3 = 4'h8,
    TNA_OP_WRITE_T3_RELOAD_HIGH = 4'h9,
    TNA_OP_T3_FROM_RELOAD_LOW = 4'hA,
    TNA_OP_TEST_T1_FLAG = 4'hB,
    TNA_OP_TEST_T2_FLAG = 4'hC,
    TNA_OP_TEST_T3_FLAG = 4'hD
  } tna_op_type;

endpackage : tna_pkg

// *** design/tna_timer_nibble_access.sv ***
/*
  tna_timer_nibble_access: executes the timer transfer and flag test
  operations of a 4-bit cpu core, moving nibbles between cpu registers
  a/b and the prescaler, the three timers and their reload registers.
  outputs: read results come back one cycle after the operation with an
  ab_write pulse; load pulses carry load_value into the counters in that
  same cycle; skip_next is a one-cycle pulse; reloads and flags hold.
  assumes: op_valid is a one-cycle pulse on sys_clk from the core; timer
  counts, underflow events and control nibbles come from sys_clk logic.
  assumes: the counters act on a load pulse in the cycle it stands and
  the core loads a and b on ab_write; reset_n is synchronous, active low.
*/
// Summary of operation
// - prescaler read puts upper count nibble in b, lower in a.
// - prescaler write loads b high, a low into counter and reload together.
// - timer 1 read puts upper count nibble in b, lower in a.
// - timer 1 write loads b high, a low into count and reload together.
// - timer 1 reload-only write loads b:a into reload, count untouched.
// - timer 2 read puts upper count nibble in b, lower in a.
// - timer 2 write loads b high, a low into count and reload together.
// - timer 3 read puts upper count nibble in b, lower in a.
// - timer 3 write loads b:a into count and low reload register.
// - high reload write takes b:a, leaving timer 3 and low reload alone.
// - a transfer copies timer 3 low reload into timer 3 count.
// - timer 1 test with enable 0 skips and clears when flag set.
// - timer 1 test with enable bit 2 of first control set is a no-op.
// - timer 2 test with enable 0 skips and clears when flag set.
// - timer 2 test with enable bit 3 of first control set is a no-op.
// - timer 3 test with enable 0 skips and clears when flag set.
// - timer 3 test with enable bit 0 of second control set is a no-op.
`timescale 1ns/1ps

module tna_timer_nibble_access #(
  parameter int CNT_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire tna_pkg::tna_op_type op_code,
  input wire logic [3:0] reg_a_in,
  input wire logic [3:0] reg_b_in,
  input wire logic [3:0] irq_ctrl_first,
  input wire logic [3:0] irq_ctrl_second,
  input wire logic [7:0] prescale_count,
  input wire logic [7:0] first_timer_count,
  input wire logic [7:0] second_timer_count,
  input wire logic [7:0] third_timer_count,
  input wire logic first_timer_event,
  input wire logic second_timer_event,
  input wire logic third_timer_event,
  output logic [3:0] reg_a_out,
  output logic [3:0] reg_b_out,
  output logic ab_write,
  output logic skip_next,
  output logic prescale_load,
  output logic first_timer_load,
  output logic second_timer_load,
  output logic third_timer_load,
  output logic [7:0] load_value,
  output logic [7:0] prescale_reload,
  output logic [7:0] first_timer_reload,
  output logic [7:0] second_timer_reload,
  output logic [7:0] third_timer_reload_low,
  output logic [7:0] third_timer_reload_high,
  output logic first_timer_irq_flag,
  output logic second_timer_irq_flag,
  output logic third_timer_irq_flag
);
  import tna_pkg::*;

  // elaboration checks on the widths the nibble paths are wired for
  if (CNT_W != TNA_CNT_W) begin : g_bad_cnt_w
    $error("tna_timer_nibble_access: CNT_W must be 8");
  end

  if (TNA_NIB_W != 4) begin : g_bad_nib_w
    $error("tna_timer_nibble_access: nibble paths are four bits wide");
  end

  if (CNT_W != 2 * TNA_NIB_W) begin : g_bad_nib_split
    $error("tna_timer_nibble_access: CNT_W must split into two nibbles");
  end

  if ($bits(tna_op_type) != TNA_OP_W) begin : g_bad_op_w
    $error("tna_timer_nibble_access: operation code width mismatch");
  end

  if (TNA_FIRST_TIMER_IRQ_ENABLE_BIT >= TNA_NIB_W ||
      TNA_SECOND_TIMER_IRQ_ENABLE_BIT >= TNA_NIB_W ||
      TNA_THIRD_TIMER_IRQ_ENABLE_BIT >= TNA_NIB_W) begin : g_bad_enable_bit
    $error("tna_timer_nibble_access: enable bit outside its control nibble");
  end

  typedef struct packed {
    logic [3:0] a;
    logic [3:0] b;
    logic ab_write;
    logic skip;
    logic ps_load;
    logic t1_load;
    logic t2_load;
    logic t3_load;
    logic [7:0] load_value;
    logic [7:0] ps_reload;
    logic [7:0] t1_reload;
    logic [7:0] t2_reload;
    logic [7:0] t3_reload_low;
    logic [7:0] t3_reload_high;
    logic [2:0] flags;
  } tna_state_type;

  // every register cleared; loads and pulses idle
  localparam tna_state_type STATE_RESET = '{
    a: TNA_NIB_RESET,
    b: TNA_NIB_RESET,
    ab_write: 1'h0,
    skip: 1'h0,
    ps_load: 1'h0,
    t1_load: 1'h0,
    t2_load: 1'h0,
    t3_load: 1'h0,
    load_value: TNA_RELOAD_RESET,
    ps_reload: TNA_RELOAD_RESET,
    t1_reload: TNA_RELOAD_RESET,
    t2_reload: TNA_RELOAD_RESET,
    t3_reload_low: TNA_RELOAD_RESET,
    t3_reload_high: TNA_RELOAD_RESET,
    flags: 3'h0
  };

  tna_state_type state_q;
  tna_state_type state_d;

  // b is the upper nibble, a the lower
  function automatic logic [7:0] join_nibbles(input logic [3:0] hi, input logic [3:0] lo);
    return {hi, lo};
  endfunction : join_nibbles

  // returns {skip, clear}: no-op while enabled, else skip and clear on set flag
  function automatic logic [1:0] flag_test(input logic enable, input logic flag);
    if (enable) begin
      return 2'h0;
    end else begin
      return {flag, flag};
    end
  endfunction : flag_test

  // upper nibble of a count, bound for b
  function automatic logic [3:0] hi_nib(input logic [7:0] word);
    return word[7:4];
  endfunction : hi_nib

  // lower nibble of a count, bound for a
  function automatic logic [3:0] lo_nib(input logic [7:0] word);
    return word[3:0];
  endfunction : lo_nib

  // strobe for one operation code
  function automatic logic op_hit(input logic valid, input tna_op_type code,
                                  input tna_op_type want);
    return valid && (code == want);
  endfunction : op_hit

  logic [2:0] event_in;
  logic [2:0] enable_in;
  logic [2:0] test_sel;
  logic [2:0] test_skip;
  logic [2:0] test_clear;
  logic [7:0] ab_word;

  // per-timer vectors, index 0 is timer 1
  assign event_in = {third_timer_event, second_timer_event, first_timer_event};
  assign enable_in = {irq_ctrl_second[TNA_THIRD_TIMER_IRQ_ENABLE_BIT],
                      irq_ctrl_first[TNA_SECOND_TIMER_IRQ_ENABLE_BIT],
                      irq_ctrl_first[TNA_FIRST_TIMER_IRQ_ENABLE_BIT]};
  assign test_sel = {op_hit(op_valid, op_code, TNA_OP_TEST_T3_FLAG),
                     op_hit(op_valid, op_code, TNA_OP_TEST_T2_FLAG),
                     op_hit(op_valid, op_code, TNA_OP_TEST_T1_FLAG)};
  // write ops take b:a as one word
  assign ab_word = join_nibbles(reg_b_in, reg_a_in);

  // one flag tester per timer; acts only when its own test is the op
  for (genvar i = 0; i < 3; i++) begin : g_flag_test
    logic [1:0] result;
    assign result = flag_test(enable_in[i], state_q.flags[i]);
    assign test_skip[i] = test_sel[i] && result[1];
    assign test_clear[i] = test_sel[i] && result[0];
  end

  always_comb begin
    state_d = state_q;
    // pulses last one cycle
    state_d.ab_write = 1'h0;
    state_d.skip = 1'h0;
    state_d.ps_load = 1'h0;
    state_d.t1_load = 1'h0;
    state_d.t2_load = 1'h0;
    state_d.t3_load = 1'h0;

    state_d.skip = |test_skip;
    // an underflow in the clearing cycle is kept
    state_d.flags = (state_q.flags & ~test_clear) | event_in;

    if (op_valid) begin
      // reads: b takes the upper nibble, a the lower
      case (op_code)
        TNA_OP_READ_PRESCALE: begin
          state_d.b = hi_nib(prescale_count);
          state_d.a = lo_nib(prescale_count);
          state_d.ab_write = 1'h1;
        end
        TNA_OP_WRITE_PRESCALE: begin
          // counter and reload take the same word
          state_d.ps_reload = ab_word;
          state_d.load_value = ab_word;
          state_d.ps_load = 1'h1;
        end
        TNA_OP_READ_T1: begin
          state_d.b = hi_nib(first_timer_count);
          state_d.a = lo_nib(first_timer_count);
          state_d.ab_write = 1'h1;
        end
        TNA_OP_WRITE_T1: begin
          // count and reload take the same word
          state_d.t1_reload = ab_word;
          state_d.load_value = ab_word;
          state_d.t1_load = 1'h1;
        end
        TNA_OP_WRITE_T1_RELOAD_ONLY: begin
          // no load pulse; running count untouched
          state_d.t1_reload = ab_word;
        end
        TNA_OP_READ_T2: begin
          state_d.b = hi_nib(second_timer_count);
          state_d.a = lo_nib(second_timer_count);
          state_d.ab_write = 1'h1;
        end
        TNA_OP_WRITE_T2: begin
          // count and reload take the same word
          state_d.t2_reload = ab_word;
          state_d.load_value = ab_word;
          state_d.t2_load = 1'h1;
        end
        TNA_OP_READ_T3: begin
          state_d.b = hi_nib(third_timer_count);
          state_d.a = lo_nib(third_timer_count);
          state_d.ab_write = 1'h1;
        end
        TNA_OP_WRITE_T3: begin
          // count and low reload take the word; high reload has its own op
          state_d.t3_reload_low = ab_word;
          state_d.load_value = ab_word;
          state_d.t3_load = 1'h1;
        end
        TNA_OP_WRITE_T3_RELOAD_HIGH: begin
          // no load pulse; timer 3 and low reload keep
          state_d.t3_reload_high = ab_word;
        end
        TNA_OP_T3_FROM_RELOAD_LOW: begin
          // low reload as it stood before this op
          state_d.load_value = state_q.t3_reload_low;
          state_d.t3_load = 1'h1;
        end
        TNA_OP_TEST_T1_FLAG,
        TNA_OP_TEST_T2_FLAG,
        TNA_OP_TEST_T3_FLAG: begin
          // the flag testers above do the work
        end
        default: begin
          // unused codes do nothing
        end
      endcase
    end
  end

  // synchronous reset of the whole state register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // all outputs straight from the state register
  assign reg_a_out = state_q.a;
  assign reg_b_out = state_q.b;
  assign ab_write = state_q.ab_write;
  assign skip_next = state_q.skip;
  assign prescale_load = state_q.ps_load;
  assign first_timer_load = state_q.t1_load;
  assign second_timer_load = state_q.t2_load;
  assign third_timer_load = state_q.t3_load;
  assign load_value = state_q.load_value;
  assign prescale_reload = state_q.ps_reload;
  assign first_timer_reload = state_q.t1_reload;
  assign second_timer_reload = state_q.t2_reload;
  assign third_timer_reload_low = state_q.t3_reload_low;
  assign third_timer_reload_high = state_q.t3_reload_high;
  assign first_timer_irq_flag = state_q.flags[0];
  assign second_timer_irq_flag = state_q.flags[1];
  assign third_timer_irq_flag = state_q.flags[2];

endmodule : tna_timer_nibble_access

// *** verification/tna_core_model.sv ***
/*
  tna_core_model: the cpu core side, holding registers a and b.
  assumes: same sys_clk and reset_n as the access unit.
*/
`timescale 1ns/1ps
module tna_core_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ld,
  input wire logic [3:0] ld_a,
  input wire logic [3:0] ld_b,
  input wire logic ab_write,
  input wire logic [3:0] reg_a_out,
  input wire logic [3:0] reg_b_out,
  output logic [3:0] reg_a,
  output logic [3:0] reg_b
);
  // read results win over the bench's own loads
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_a <= 4'h0;
      reg_b <= 4'h0;
    end else if (ab_write) begin
      reg_a <= reg_a_out;
      reg_b <= reg_b_out;
    end else if (ld) begin
      reg_a <= ld_a;
      reg_b <= ld_b;
    end
  end
endmodule : tna_core_model

// *** verification/tna_chk.sv ***
/*
  tna_chk: port assertions for the timer nibble access unit.
  assumes: bound to tna_timer_nibble_access, single sys_clk domain.
*/
`timescale 1ns/1ps
module tna_chk import tna_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire tna_op_type op_code,
  input wire logic [3:0] reg_a_in,
  input wire logic [3:0] reg_b_in,
  input wire logic [3:0] irq_ctrl_first,
  input wire logic [7:0] prescale_count,
  input wire logic first_timer_event,
  input wire logic [3:0] reg_a_out,
  input wire logic [3:0] reg_b_out,
  input wire logic ab_write,
  input wire logic skip_next,
  input wire logic prescale_load,
  input wire logic first_timer_load,
  input wire logic third_timer_load,
  input wire logic [7:0] load_value,
  input wire logic [7:0] prescale_reload,
  input wire logic [7:0] first_timer_reload,
  input wire logic [7:0] third_timer_reload_low,
  input wire logic [7:0] third_timer_reload_high,
  input wire logic first_timer_irq_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire [7:0] ba = {reg_b_in, reg_a_in};
  wire t1t = op_valid && op_code == TNA_OP_TEST_T1_FLAG;
  property p_rd_pre; op_valid && op_code == TNA_OP_READ_PRESCALE
    |=> ab_write && {reg_b_out, reg_a_out} == $past(prescale_count); endproperty
  a_rd_pre: assert property (p_rd_pre) else $error("prescale read");
  property p_wr_pre; op_valid && op_code == TNA_OP_WRITE_PRESCALE
    |=> prescale_load && prescale_reload == $past(ba) && load_value == $past(ba); endproperty
  a_wr_pre: assert property (p_wr_pre) else $error("prescale write");
  property p_wr_t1; op_valid && op_code == TNA_OP_WRITE_T1
    |=> first_timer_load && first_timer_reload == $past(ba) && load_value == $past(ba); endproperty
  a_wr_t1: assert property (p_wr_t1) else $error("timer 1 write");
  property p_ro_t1; op_valid && op_code == TNA_OP_WRITE_T1_RELOAD_ONLY
    |=> !first_timer_load && first_timer_reload == $past(ba) && $stable(load_value); endproperty
  a_ro_t1: assert property (p_ro_t1) else $error("timer 1 reload only");
  property p_hi_t3; op_valid && op_code == TNA_OP_WRITE_T3_RELOAD_HIGH |=> !third_timer_load
    && third_timer_reload_high == $past(ba) && $stable(third_timer_reload_low); endproperty
  a_hi_t3: assert property (p_hi_t3) else $error("timer 3 high reload");
  property p_t3_rl; op_valid && op_code == TNA_OP_T3_FROM_RELOAD_LOW
    |=> third_timer_load && load_value == $past(third_timer_reload_low); endproperty
  a_t3_rl: assert property (p_t3_rl) else $error("timer 3 from reload");
  property p_t1_skip; t1t && !irq_ctrl_first[2] && first_timer_irq_flag && !first_timer_event
    |=> skip_next && !first_timer_irq_flag; endproperty
  a_t1_skip: assert property (p_t1_skip) else $error("timer 1 flag skip");
  property p_t1_nop; t1t && irq_ctrl_first[2] && !first_timer_event
    |=> !skip_next && $rose(first_timer_irq_flag) == 1'b0 && $stable(first_timer_irq_flag); endproperty
  a_t1_nop: assert property (p_t1_nop) else $error("timer 1 flag nop");
endmodule : tna_chk
bind tna_timer_nibble_access tna_chk chk (.sys_clk, .reset_n, .op_valid, .op_code, .reg_a_in,
  .reg_b_in, .irq_ctrl_first, .prescale_count, .first_timer_event, .reg_a_out, .reg_b_out,
  .ab_write, .skip_next, .prescale_load, .first_timer_load, .third_timer_load, .load_value,
  .prescale_reload, .first_timer_reload, .third_timer_reload_low, .third_timer_reload_high,
  .first_timer_irq_flag);

// *** verification/tna_timer_nibble_access_tb_top.sv ***
/*
  tna_timer_nibble_access_tb_top: transfer and flag test sequences.
  assumes: tna_core_model holds registers a and b; counts driven here.
*/
`timescale 1ns/1ps
module tna_timer_nibble_access_tb_top;
  import tna_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic op_valid = 1'b0;
  tna_op_type op_code = TNA_OP_READ_PRESCALE;
  tna_op_type tst [3] = '{TNA_OP_TEST_T1_FLAG, TNA_OP_TEST_T2_FLAG, TNA_OP_TEST_T3_FLAG};
  logic ld = 1'b0;
  logic [3:0] ld_a = 4'h0;
  logic [3:0] ld_b = 4'h0;
  logic [3:0] irq_ctrl_first = 4'h3;
  logic [3:0] irq_ctrl_second = 4'hE;
  logic [7:0] cnt [4] = '{8'hA5, 8'h3C, 8'h96, 8'hE1};
  logic [2:0] ev = 3'h0;
  wire logic [2:0] flg;
  logic [3:0] reg_a_in, reg_b_in, reg_a_out, reg_b_out;
  logic ab_write, skip_next, prescale_load, first_timer_load, second_timer_load, third_timer_load;
  logic [7:0] load_value, prescale_reload, first_timer_reload, second_timer_reload;
  logic [7:0] third_timer_reload_low, third_timer_reload_high;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #25 sys_clk = ~sys_clk;
  tna_core_model core (.sys_clk, .reset_n, .ld, .ld_a, .ld_b, .ab_write, .reg_a_out,
    .reg_b_out, .reg_a(reg_a_in), .reg_b(reg_b_in));
  tna_timer_nibble_access #(.CNT_W(8)) uut (.sys_clk, .reset_n, .op_valid, .op_code,
    .reg_a_in, .reg_b_in, .irq_ctrl_first, .irq_ctrl_second, .prescale_count(cnt[0]),
    .first_timer_count(cnt[1]), .second_timer_count(cnt[2]), .third_timer_count(cnt[3]),
    .first_timer_event(ev[0]), .second_timer_event(ev[1]), .third_timer_event(ev[2]),
    .reg_a_out, .reg_b_out, .ab_write, .skip_next, .prescale_load, .first_timer_load,
    .second_timer_load, .third_timer_load, .load_value, .prescale_reload, .first_timer_reload,
    .second_timer_reload, .third_timer_reload_low, .third_timer_reload_high,
    .first_timer_irq_flag(flg[0]), .second_timer_irq_flag(flg[1]), .third_timer_irq_flag(flg[2]));
  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // load b:a in the core, issue one op, check the pulses it answers with
  task automatic op(input tna_op_type c, input logic [7:0] v, input logic [5:0] p);
    @(posedge sys_clk);
    #1 {ld, ld_b, ld_a} = {1'b1, v};
    @(posedge sys_clk);
    #1 ld = 1'b0;
    op_valid = 1'b1;
    op_code = c;
    @(posedge sys_clk);
    #1 op_valid = 1'b0;
    chk({2'h0, ab_write, skip_next, prescale_load, first_timer_load, second_timer_load,
      third_timer_load}, {2'h0, p});
  endtask : op
  task automatic rd(input tna_op_type c, input logic [7:0] exp);
    op(c, 8'h77, 6'h20);
    @(posedge sys_clk);
    #1 chk({reg_b_in, reg_a_in}, exp);
  endtask : rd
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    rd(TNA_OP_READ_PRESCALE, 8'hA5);
    rd(TNA_OP_READ_T1, 8'h3C);
    rd(TNA_OP_READ_T2, 8'h96);
    rd(TNA_OP_READ_T3, 8'hE1);
    op(TNA_OP_WRITE_PRESCALE, 8'h5A, 6'h08);
    chk(prescale_reload, 8'h5A);
    op(TNA_OP_WRITE_T1, 8'hC1, 6'h04);
    chk(first_timer_reload, 8'hC1);
    op(TNA_OP_WRITE_T1_RELOAD_ONLY, 8'h1E, 6'h00);
    chk(first_timer_reload, 8'h1E);
    op(TNA_OP_WRITE_T3, 8'h81, 6'h01);
    chk(third_timer_reload_low, 8'h81);
    chk(load_value, 8'h81);
    op(TNA_OP_WRITE_T3_RELOAD_HIGH, 8'h7E, 6'h00);
    chk(third_timer_reload_high, 8'h7E);
    chk(third_timer_reload_low, 8'h81);
    op(TNA_OP_WRITE_T2, 8'h69, 6'h02);
    chk(second_timer_reload, 8'h69);
    chk(load_value, 8'h69);
    op(TNA_OP_T3_FROM_RELOAD_LOW, 8'h00, 6'h01);
    chk(load_value, 8'h81);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      #1 ev = 3'h1 << i;
      @(posedge sys_clk);
      #1 ev = 3'h0;
      {irq_ctrl_second[0], irq_ctrl_first[3], irq_ctrl_first[2]} = 3'h1 << i;
      op(tst[i], 8'h00, 6'h00);
      chk({5'h0, flg}, 8'h01 << i);
      {irq_ctrl_second[0], irq_ctrl_first[3], irq_ctrl_first[2]} = 3'h0;
      op(tst[i], 8'h00, 6'h10);
      chk({5'h0, flg}, 8'h00);
      op(tst[i], 8'h00, 6'h00);
    end
    print_verdict();
  end
endmodule : tna_timer_nibble_access_tb_top
